/* File: rtl/pcaw_core.sv */
// counter array core: 16-bit counter, snapshot read, overflow flag, mode bits and watchdog reset
// What this block does
// - 16-bit counter; low read snapshots high byte
// - byte reads never disturb the counting
// - three-bit select picks one of six timebases
// - external oscillator/8 synchronised before use
// - wrap sets overflow flag; enable raises request
// - flag stays set; software clears it
// - request needs global and array enables
// - idle-suspend halts counter and watchdog in idle
// - compare value checked against counter high byte
// - low overflow on high match resets system
// - timeout is 256*offset plus 256 minus low
// - any compare write reloads the watchdog
// - writing match flag one forces reset while enabled
// - timebase and idle bits frozen while enabled
// - enable bit or lock bit enables watchdog
// - lock stays set until system reset
// - reset: enabled, clock/12, low and offset zero
// - wrap during flag register write never lost
// - software may set the flag by writing one
`timescale 1ns/1ns
`include "pcaw_map.svh"
module pcaw_core (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 wr_en,
	input  wire pcaw_pkg::pcaw_addr_t wr_addr,
	input  wire pcaw_pkg::pcaw_byte_t wr_data,
	input  wire logic                 rd_en,
	input  wire pcaw_pkg::pcaw_addr_t rd_addr,
	output logic [7:0]                rd_data,
	input  wire logic                 cpu_idle,
	input  wire logic                 global_irq_enable,
	input  wire logic                 array_irq_enable,
	input  wire logic                 timer0_ovf,
	input  wire logic                 ext_count_in,
	input  wire logic                 ext_osc_div8,
	output logic                      irq,
	output logic                      wd_reset,
	output logic                      wd_enabled
);
	import pcaw_pkg::*;

	pcaw_if lnk ();

	pcaw_core_state_t s_q;
	pcaw_core_state_t s_d;

	logic       wd_en;
	logic       run;
	logic       step;
	logic       lo_full;
	logic       wrap;
	logic       wr_ctl;
	logic       wr_mode;
	logic       wr_lo;
	logic       wr_hi;
	logic       forced;
	pcaw_byte_t ctl_view;
	pcaw_byte_t mode_view;

	function automatic logic hit(input logic en, input pcaw_addr_t a, input pcaw_addr_t r);
		hit = en & (a == r);
	endfunction

	pcaw_timebase pcaw_timebase_inst (
		.clk          (clk),
		.rstn         (rstn),
		.timer0_ovf   (timer0_ovf),
		.ext_count_in (ext_count_in),
		.ext_osc_div8 (ext_osc_div8),
		.tb           (lnk.tb)
	);

	pcaw_wdcmp pcaw_wdcmp_inst (
		.clk  (clk),
		.rstn (rstn),
		.wd   (lnk.wd)
	);

	always_comb begin
		s_d = s_q;

		wd_en = s_q.watchdog_enable_bit | s_q.watchdog_lock_bit;

		// counting stops in idle only when asked to; the watchdog rides on the same step
		run = ~(cpu_idle & s_q.idle_sus);
		step = run & lnk.tick;

		lo_full = (s_q.cnt_lo == `PCAW_BYTE_FULL);
		wrap = step & lo_full & (s_q.cnt_hi == `PCAW_BYTE_FULL);

		wr_ctl = hit(wr_en, wr_addr, `PCAW_REG_CTL);
		wr_mode = hit(wr_en, wr_addr, `PCAW_REG_MODE);
		wr_lo = hit(wr_en, wr_addr, `PCAW_REG_CNT_LO);
		wr_hi = hit(wr_en, wr_addr, `PCAW_REG_CNT_HI);

		// links to timebase and watchdog compare
		lnk.sel = s_q.cps;
		lnk.step = step;
		lnk.wd_en = wd_en;
		lnk.cnt_lo = s_q.cnt_lo;
		lnk.cnt_hi = s_q.cnt_hi;
		lnk.wr_ofs = hit(wr_en, wr_addr, `PCAW_REG_WD_OFS);
		lnk.wr_cmp = hit(wr_en, wr_addr, `PCAW_REG_WD_CMP);
		lnk.wr_data = wr_data;

		// counter advance; reads never touch the count
		if (step) begin
			s_d.cnt_lo = s_q.cnt_lo + 8'h01;
			if (lo_full) begin
				s_d.cnt_hi = s_q.cnt_hi + 8'h01;
			end
		end
		// a software write to a byte takes precedence over the advance of that byte
		if (wr_lo) begin
			s_d.cnt_lo = wr_data;
		end
		if (wr_hi) begin
			s_d.cnt_hi = wr_data;
		end

		// overflow flag: software write first, hardware set last so it always wins
		if (wr_ctl) begin
			s_d.cf = wr_data[`PCAW_CTL_CF];
		end
		if (wrap) begin
			s_d.cf = 1'b1;
		end

		// mode register
		if (wr_mode) begin
			s_d.ecf = wr_data[`PCAW_MD_ECF];
			s_d.watchdog_enable_bit = wr_data[`PCAW_MD_WATCHDOG_ENABLE_BIT];
			if (wr_data[`PCAW_MD_WATCHDOG_LOCK_BIT]) begin
				s_d.watchdog_lock_bit = 1'b1;
			end
			// timebase and idle option only change while the watchdog is off
			if (!wd_en) begin
				s_d.idle_sus = wr_data[`PCAW_MD_IDLE];
				s_d.cps = wr_data[`PCAW_MD_CPS_HI:`PCAW_MD_CPS_LO];
			end
		end

		// forced reset through the module 4 match flag
		forced = wr_ctl & wr_data[`PCAW_CTL_MF4] & wd_en;
		s_d.wd_rst = forced | lnk.timeout;

		// request gated by both enables, taken from the registered flag
		s_d.irq = s_q.cf & s_q.ecf & global_irq_enable & array_irq_enable;

		// register views; unused bits read zero
		ctl_view = '0;
		ctl_view[`PCAW_CTL_CF] = s_q.cf;
		mode_view = '0;
		mode_view[`PCAW_MD_IDLE] = s_q.idle_sus;
		mode_view[`PCAW_MD_WATCHDOG_ENABLE_BIT] = s_q.watchdog_enable_bit;
		mode_view[`PCAW_MD_WATCHDOG_LOCK_BIT] = s_q.watchdog_lock_bit;
		mode_view[`PCAW_MD_CPS_HI:`PCAW_MD_CPS_LO] = s_q.cps;
		mode_view[`PCAW_MD_ECF] = s_q.ecf;

		// read port: data registered, low read captures the high byte
		if (rd_en) begin
			unique case (rd_addr)
				`PCAW_REG_CTL: begin
					s_d.rd_data = ctl_view;
				end
				`PCAW_REG_MODE: begin
					s_d.rd_data = mode_view;
				end
				`PCAW_REG_CNT_LO: begin
					s_d.rd_data = s_q.cnt_lo;
					s_d.snap = s_q.cnt_hi;
				end
				`PCAW_REG_CNT_HI: begin
					s_d.rd_data = s_q.snap;
				end
				`PCAW_REG_WD_OFS: begin
					s_d.rd_data = lnk.ofs;
				end
				`PCAW_REG_WD_CMP: begin
					s_d.rd_data = lnk.cmp;
				end
				default: begin
					s_d.rd_data = `PCAW_BYTE_ZERO;
				end
			endcase
		end

		rd_data = s_q.rd_data;
		irq = s_q.irq;
		wd_reset = s_q.wd_rst;
		wd_enabled = wd_en;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q.cnt_lo <= `PCAW_BYTE_ZERO;
			s_q.cnt_hi <= `PCAW_BYTE_ZERO;
			s_q.snap <= `PCAW_BYTE_ZERO;
			s_q.cf <= 1'b0;
			s_q.ecf <= 1'b0;
			s_q.idle_sus <= 1'b0;
			s_q.watchdog_enable_bit <= `PCAW_RST_WATCHDOG_ENABLE_BIT;
			s_q.watchdog_lock_bit <= 1'b0;
			s_q.cps <= `PCAW_RST_CPS;
			s_q.rd_data <= `PCAW_BYTE_ZERO;
			s_q.wd_rst <= 1'b0;
			s_q.irq <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

/* File: rtl/pcaw_if.sv */
// links between the core, its timebase and its watchdog compare
`timescale 1ns/1ns
interface pcaw_if;
	import pcaw_pkg::*;
	pcaw_tb_t   sel;
	logic       tick;
	logic       step;
	logic       wd_en;
	pcaw_byte_t cnt_lo;
	pcaw_byte_t cnt_hi;
	logic       wr_ofs;
	logic       wr_cmp;
	pcaw_byte_t wr_data;
	pcaw_byte_t ofs;
	pcaw_byte_t cmp;
	logic       timeout;

	modport core (output sel, output step, output wd_en, output cnt_lo, output cnt_hi,
		output wr_ofs, output wr_cmp, output wr_data, input tick, input ofs, input cmp, input timeout);
	modport tb (input sel, output tick);
	modport wd (input step, input wd_en, input cnt_lo, input cnt_hi, input wr_ofs, input wr_cmp,
		input wr_data, output ofs, output cmp, output timeout);
endinterface

/* File: rtl/pcaw_map.svh */
// register offsets, field positions, reset values and timing counts of the counter array watchdog
`ifndef PCAW_MAP_SVH
`define PCAW_MAP_SVH

`define PCAW_REG_CTL      3'h0
`define PCAW_REG_MODE     3'h1
`define PCAW_REG_CNT_LO   3'h2
`define PCAW_REG_CNT_HI   3'h3
`define PCAW_REG_WD_OFS   3'h4
`define PCAW_REG_WD_CMP   3'h5

`define PCAW_CTL_CF       7
`define PCAW_CTL_MF4      4
`define PCAW_MD_IDLE      7
`define PCAW_MD_WATCHDOG_ENABLE_BIT      6
`define PCAW_MD_WATCHDOG_LOCK_BIT     5
`define PCAW_MD_CPS_HI    3
`define PCAW_MD_CPS_LO    1
`define PCAW_MD_ECF       0

`define PCAW_TB_DIV12     3'h0
`define PCAW_TB_DIV4      3'h1
`define PCAW_TB_T0OVF     3'h2
`define PCAW_TB_ECI       3'h3
`define PCAW_TB_SYSTEM_CLOCK    3'h4
`define PCAW_TB_EXTOSC    3'h5

`define PCAW_DIV12_LAST   4'hb
`define PCAW_DIV4_LAST    2'h3

`define PCAW_BYTE_ZERO    8'h00
`define PCAW_BYTE_FULL    8'hff
`define PCAW_RST_CPS      3'h0
`define PCAW_RST_WATCHDOG_ENABLE_BIT     1'b1
`define PCAW_RST_CMP      8'h00

`endif

/* File: rtl/pcaw_pkg.sv */
// types shared by the counter array watchdog modules
package pcaw_pkg;
	typedef logic [2:0] pcaw_addr_t;
	typedef logic [2:0] pcaw_tb_t;
	typedef logic [7:0] pcaw_byte_t;

	typedef struct packed {
		logic [3:0] pre12;
		logic [1:0] pre4;
		logic       eci_q;
		logic       eci_prev;
		logic       osc_s1;
		logic       osc_s2;
		logic       osc_prev;
	} pcaw_tb_state_t;

	typedef struct packed {
		pcaw_byte_t ofs;
		pcaw_byte_t cmp;
	} pcaw_wd_state_t;

	typedef struct packed {
		pcaw_byte_t cnt_lo;
		pcaw_byte_t cnt_hi;
		pcaw_byte_t snap;
		logic       cf;
		logic       ecf;
		logic       idle_sus;
		logic       watchdog_enable_bit;
		logic       watchdog_lock_bit;
		pcaw_tb_t   cps;
		pcaw_byte_t rd_data;
		logic       wd_rst;
		logic       irq;
	} pcaw_core_state_t;
endpackage

/* File: rtl/pcaw_timebase.sv */
// timebase selection: prescalers, edge detect and the synchronised external oscillator
`timescale 1ns/1ns
`include "pcaw_map.svh"
module pcaw_timebase (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic timer0_ovf,
	input  wire logic ext_count_in,
	input  wire logic ext_osc_div8,
	pcaw_if.tb        tb
);
	import pcaw_pkg::*;

	pcaw_tb_state_t s_q;
	pcaw_tb_state_t s_d;
	logic           t12;
	logic           t4;
	logic           eci_fall;
	logic           osc_rise;

	always_comb begin
		s_d = s_q;
		t12 = (s_q.pre12 == `PCAW_DIV12_LAST);
		t4 = (s_q.pre4 == `PCAW_DIV4_LAST);
		s_d.pre12 = t12 ? '0 : s_q.pre12 + 4'h1;
		s_d.pre4 = s_q.pre4 + 2'h1;
		// one sample then a delayed copy; a level held for one clock is enough for an edge
		s_d.eci_q = ext_count_in;
		s_d.eci_prev = s_q.eci_q;
		eci_fall = s_q.eci_prev & ~s_q.eci_q;
		// two-stage synchroniser, only the second stage feeds the edge detect
		s_d.osc_s1 = ext_osc_div8;
		s_d.osc_s2 = s_q.osc_s1;
		s_d.osc_prev = s_q.osc_s2;
		osc_rise = s_q.osc_s2 & ~s_q.osc_prev;
		unique case (tb.sel)
			`PCAW_TB_DIV12:  tb.tick = t12;
			`PCAW_TB_DIV4:   tb.tick = t4;
			`PCAW_TB_T0OVF:  tb.tick = timer0_ovf;
			`PCAW_TB_ECI:    tb.tick = eci_fall;
			`PCAW_TB_SYSTEM_CLOCK: tb.tick = 1'b1;
			`PCAW_TB_EXTOSC: tb.tick = osc_rise;
			default:         tb.tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

/* File: rtl/pcaw_wdcmp.sv */
// watchdog compare register, low offset and timeout detect
`timescale 1ns/1ns
`include "pcaw_map.svh"
module pcaw_wdcmp (
	input  wire logic clk,
	input  wire logic rstn,
	pcaw_if.wd        wd
);
	import pcaw_pkg::*;

	pcaw_wd_state_t s_q;
	pcaw_wd_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (wd.wr_ofs) begin
			s_d.ofs = wd.wr_data;
		end
		// the written value itself is discarded: any write restarts the count
		if (wd.wr_cmp) begin
			s_d.cmp = pcaw_byte_t'(wd.cnt_hi + s_q.ofs);
		end
		wd.ofs = s_q.ofs;
		wd.cmp = s_q.cmp;
		// low byte overflow while high byte matches
		wd.timeout = wd.wd_en & wd.step & (wd.cnt_lo == `PCAW_BYTE_FULL)
			& (wd.cnt_hi == s_q.cmp);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q.ofs <= `PCAW_BYTE_ZERO;
			s_q.cmp <= `PCAW_RST_CMP;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

/* File: verif/pcaw_core_chk.sv */
// port assertions for the counter array watchdog core
`timescale 1ns/1ns
module pcaw_core_chk (
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire logic                 wr_en,
	input wire pcaw_pkg::pcaw_addr_t wr_addr,
	input wire pcaw_pkg::pcaw_byte_t wr_data,
	input wire logic [7:0]           rd_data,
	input wire logic                 global_irq_enable,
	input wire logic                 array_irq_enable,
	input wire logic                 irq,
	input wire logic                 wd_reset,
	input wire logic                 wd_enabled
);
	import pcaw_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence s_force;
		wr_en && wr_addr == 3'h0 && wr_data[4];
	endsequence
	sequence s_mode_on;
		wr_en && wr_addr == 3'h1 && (wr_data[6] || wr_data[5]);
	endsequence
	a_forced_reset: assert property (s_force ##0 wd_enabled |=> wd_reset ##1 !wd_reset)
		else $error("forced reset not pulsed");
	a_forced_ignored: assert property (s_force ##0 !wd_enabled |=> !wd_reset)
		else $error("forced reset while disabled");
	a_reset_enabled: assert property (wd_reset |-> $past(wd_enabled))
		else $error("watchdog reset while disabled");
	a_mode_enable: assert property (s_mode_on |=> wd_enabled)
		else $error("watchdog not enabled by mode write");
	// eight cycles is enough to span the lock then clear attempt
	a_lock_holds: assert property (s_mode_on ##0 wr_data[5] |=> wd_enabled [*8])
		else $error("lock released early");
	a_irq_gated: assert property (irq |-> $past(global_irq_enable && array_irq_enable))
		else $error("request without both enables");
	a_flag_sticky: assert property (irq && global_irq_enable && array_irq_enable && !wr_en && !$past(wr_en) |=> irq)
		else $error("request dropped without software");
	a_reset_default: assert property ($rose(rstn) |-> wd_enabled && !irq && !wd_reset && rd_data == 8'h00)
		else $error("wrong state after reset");
endmodule
bind pcaw_core pcaw_core_chk pcaw_core_chk_inst (.clk, .rstn, .wr_en, .wr_addr, .wr_data, .rd_data,
	.global_irq_enable, .array_irq_enable, .irq, .wd_reset, .wd_enabled);

/* File: verif/pcaw_core_tb_top.sv */
// self-checking bench for the counter array watchdog core
`timescale 1ns/1ns
module pcaw_core_tb_top;
	import pcaw_pkg::*;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       wr_en = 1'b0;
	pcaw_addr_t wr_addr = 3'h0;
	pcaw_byte_t wr_data = 8'h00;
	logic       rd_en = 1'b0;
	pcaw_addr_t rd_addr = 3'h0;
	logic [7:0] rd_data;
	logic       cpu_idle = 1'b0;
	logic       global_irq_enable = 1'b0;
	logic       array_irq_enable = 1'b0;
	logic       timer0_ovf = 1'b0;
	logic       ext_count_in = 1'b1;
	logic       ext_osc_div8 = 1'b0;
	logic       irq;
	logic       wd_reset;
	logic       wd_enabled;
	logic       seen = 1'b0;
	logic       clr = 1'b0;
	logic [3:0] ph = 4'h0;
	int         errors = 0;
	int         comparisons = 0;
	int         n;
	pcaw_byte_t a;
	pcaw_byte_t b;
	pcaw_byte_t rate [8] = '{8'h04, 8'h0c, 8'h06, 8'h0c, 8'h30, 8'h06, 8'h00, 8'h00};
	pcaw_core pcaw_core_inst (.clk, .rstn, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data, .cpu_idle,
		.global_irq_enable, .array_irq_enable, .timer0_ovf, .ext_count_in, .ext_osc_div8, .irq, .wd_reset, .wd_enabled);
	always #25 clk = ~clk;
	// free-running sources; each level of the count input is held two clocks
	always @(posedge clk) begin
		ph <= ph + 4'h1;
		ext_count_in <= ph[1];
		ext_osc_div8 <= ph[2];
		timer0_ovf <= (ph[2:0] == 3'h7);
		// the scenario clears seen through clr so that seen keeps a single driver
		seen <= (irq === 1'b1) | (seen & ~clr);
	end
	task automatic chk(input string s, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic wr(input pcaw_addr_t ad, input pcaw_byte_t d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= ad;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input pcaw_addr_t ad, output pcaw_byte_t d);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= ad;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic results();
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wt(input bit w, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge clk);
			#1;
			if ((w ? irq : wd_reset) === 1'b1) return;
		end
		errors++;
		results();
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(3'h2, a); chk("low byte", a, 8'h00);
		rd(3'h4, a); chk("offset", a, 8'h00);
		rd(3'h1, a); chk("mode", a, 8'h40);
		wt(1'b0, 4000);
		chk("default timeout", n > 3050 && n < 3090, 1'b1);
		wr(3'h1, 8'h00); #1 chk("disabled", wd_enabled, 1'b0);
		wr(3'h0, 8'h10); #1 chk("forced off", wd_reset, 1'b0);
		for (int c = 0; c < 8; c++) begin
			wr(3'h1, {4'h0, c[2:0], 1'b0});
			rd(3'h2, a);
			repeat (46) @(posedge clk);
			rd(3'h2, b);
			chk("rate", b - a, rate[c]);
		end
		wr(3'h1, 8'h89);
		@(posedge clk) cpu_idle <= 1'b1;
		wr(3'h2, 8'h05); wr(3'h3, 8'h12);
		rd(3'h2, a); chk("frozen low", a, 8'h05);
		wr(3'h3, 8'h34);
		rd(3'h3, a); chk("snapshot", a, 8'h12);
		rd(3'h2, a); rd(3'h3, a); chk("new snapshot", a, 8'h34);
		wr(3'h2, 8'hff); wr(3'h3, 8'hff);
		@(posedge clk) begin
			global_irq_enable <= 1'b1;
			array_irq_enable <= 1'b1;
			cpu_idle <= 1'b0;
		end
		wt(1'b1, 10);
		rd(3'h0, a); chk("flag", a, 8'h80);
		#100 chk("held", irq, 1'b1);
		@(posedge clk) global_irq_enable <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("gated", irq, 1'b0);
		wr(3'h0, 8'h00); rd(3'h0, a); chk("cleared", a, 8'h00);
		wr(3'h0, 8'h80); rd(3'h0, a); chk("set", a, 8'h80);
		// two phases so that one wrap lands on a control write
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) cpu_idle <= 1'b1;
			wr(3'h2, pcaw_byte_t'(240 + k)); wr(3'h3, 8'hff); wr(3'h0, 8'h00);
			@(posedge clk) begin
				clr <= 1'b1;
				global_irq_enable <= 1'b1;
				cpu_idle <= 1'b0;
			end
			@(posedge clk) clr <= 1'b0;
			repeat (14) wr(3'h0, 8'h00);
			chk("wrap in write", seen, 1'b1);
		end
		@(posedge clk) cpu_idle <= 1'b1;
		wr(3'h1, 8'hc8); wr(3'h1, 8'h40);
		rd(3'h1, a); chk("mode kept", a, 8'hc8);
		wr(3'h4, 8'h02); wr(3'h2, 8'h10); wr(3'h3, 8'h00); wr(3'h5, 8'h00);
		@(posedge clk) cpu_idle <= 1'b0;
		wt(1'b0, 900);
		chk("timeout", n > 749 && n < 757, 1'b1);
		wr(3'h0, 8'h10); #1 chk("forced", wd_reset, 1'b1);
		wr(3'h1, 8'h20); wr(3'h1, 8'h00); #1 chk("locked", wd_enabled, 1'b1);
		// let the lock assertion see its full window before the second reset
		repeat (8) @(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wr(3'h1, 8'h00); #1 chk("unlocked", wd_enabled, 1'b0);
		results();
	end
endmodule
